// File: hdl/tccp_pkg.sv
// Behaviour
// - unbuffered compare uses written value at once
// - compare only when count reaches value
// - compare event when count meets value
// - wrap event when count wraps past limit
// - link bit joins channels onto pin 0
// - last written pair takes over at wrap
// - linked: channel 1 control ignored, pin freed
// - toggle-on-wrap flips pin at limit
// - width is wrap to compare; clear/set
// - limit 255 at divide one: 256 clocks
// - value 128 of 256 gives half duty
// - linked pwm: new pair at next period
// - mode pair 0:1 unbuffered, 1:0 linked
// - halt bit set on reset
// - clear bit zeroes counter, prescaler, reads zero
// - action pair 1:0 clears, 1:1 sets
// - wrap flag set at rollover, request if enabled
package tccp_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TCCP_OFF_TIMER_CTRL = 8'h00;
  localparam logic [7:0] TCCP_OFF_COUNT = 8'h04;
  localparam logic [7:0] TCCP_OFF_LIMIT = 8'h08;
  localparam logic [7:0] TCCP_OFF_CH0_CTRL = 8'h0C;
  localparam logic [7:0] TCCP_OFF_CH0_VAL = 8'h10;
  localparam logic [7:0] TCCP_OFF_CH1_CTRL = 8'h14;
  localparam logic [7:0] TCCP_OFF_CH1_VAL = 8'h18;

  // ---------------------------------------------------------------
  // timer control field positions
  // ---------------------------------------------------------------
  localparam int TCCP_WRAP_FLAG_BIT = 7;
  localparam int TCCP_WRAP_IE_BIT = 6;
  localparam int TCCP_HALT_BIT = 5;
  localparam int TCCP_CLEAR_BIT = 4;
  localparam int TCCP_PS_LSB = 0;
  localparam logic [2:0] TCCP_PS_EXT = 3'h7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic TCCP_HALT_RST = 1'b1;
  localparam logic [2:0] TCCP_PS_RST = 3'h0;
  localparam logic [15:0] TCCP_LIMIT_RST = 16'hFFFF;
  localparam logic [15:0] TCCP_VAL_RST = 16'h0000;

  // channel control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic mode_select_high;
    logic mode_select_low;
    logic edge_level_sel_high;
    logic edge_level_sel_low;
    logic toggle_on_wrap_bit;
    logic rsvd;
  } tccp_chan_ctrl_type;

  localparam tccp_chan_ctrl_type TCCP_CHAN_CTRL_RST = 8'h00;

endpackage

// File: hdl/tccp_timer.sv
`timescale 1ns/1ps
module tccp_timer
  import tccp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_clk_pin,
  output logic [1:0] chan_pin_o,
  output logic [1:0] chan_pin_oe_n,
  output logic wrap_req,
  output logic [1:0] chan_req
);

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata;
  logic accept;

  // timer state
  logic halt_q;
  logic wrap_ie_q;
  logic wrap_flag_q;
  logic wrap_arm_q;
  logic [2:0] ps_q;
  logic [5:0] pre_q;
  logic [5:0] pre_mask;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] limit_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic tick;
  logic cnt_tick;
  logic wrap_evt;
  logic clear_cnt;
  logic wrap_req_q;

  // channel state
  tccp_chan_ctrl_type ctrl_q [2];
  logic [CNT_W-1:0] val_q [2];
  logic [1:0] arm_q;
  logic [1:0] pin_q;
  logic [1:0] oe_n_q;
  logic [1:0] chan_req_q;
  logic [1:0] cmp_evt;
  logic link;
  logic act_q;
  logic last_q;
  logic last_d;

  // write strobes, valid in the write data phase
  logic wr_tctrl;
  logic wr_limit;
  logic [1:0] wr_cctrl;
  logic [1:0] wr_val;

  assign accept = hsel & htrans[1] & hready;
  assign wr_tctrl = wr_q && (addr_q == TCCP_OFF_TIMER_CTRL);
  assign wr_limit = wr_q && (addr_q == TCCP_OFF_LIMIT);
  assign wr_cctrl[0] = wr_q && (addr_q == TCCP_OFF_CH0_CTRL);
  assign wr_cctrl[1] = wr_q && (addr_q == TCCP_OFF_CH1_CTRL);
  assign wr_val[0] = wr_q && (addr_q == TCCP_OFF_CH0_VAL);
  assign wr_val[1] = wr_q && (addr_q == TCCP_OFF_CH1_VAL);

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  // reads take one wait state so a read right behind a write sees it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
    end else begin
      wr_q <= accept & hwrite;
      rd_q <= accept & ~hwrite;
      hreadyout_q <= ~(accept & ~hwrite);
      if (accept) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // read mux, unmapped offsets read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (addr_q)
      TCCP_OFF_TIMER_CTRL: begin
        rdata[TCCP_WRAP_FLAG_BIT] = wrap_flag_q;
        rdata[TCCP_WRAP_IE_BIT] = wrap_ie_q;
        rdata[TCCP_HALT_BIT] = halt_q;
        rdata[TCCP_PS_LSB +: 3] = ps_q; // clear bit always reads zero
      end
      TCCP_OFF_COUNT: rdata[CNT_W-1:0] = cnt_q;
      TCCP_OFF_LIMIT: rdata[CNT_W-1:0] = limit_q;
      TCCP_OFF_CH0_CTRL: rdata[7:0] = ctrl_q[0]; // linked status reported here
      TCCP_OFF_CH0_VAL: rdata[CNT_W-1:0] = val_q[0];
      TCCP_OFF_CH1_CTRL: rdata[7:0] = ctrl_q[1];
      TCCP_OFF_CH1_VAL: rdata[CNT_W-1:0] = val_q[1];
      default: rdata = 32'h0000_0000;
    endcase
  end

  // read data is loaded in the wait cycle and held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      hrdata_q <= rdata;
    end
  end

  // ---------------------------------------------------------------
  // external clock pin and prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_clk_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign clear_cnt = wr_tctrl & hwdata[TCCP_CLEAR_BIT];
  assign pre_mask = 6'((7'h01 << ps_q) - 7'h01);

  // select zero ticks every clock, which gives the 256-clock period at limit 255
  always_comb begin
    if (ps_q == TCCP_PS_EXT) begin
      tick = ext_sync_q & ~ext_prev_q;
    end else begin
      tick = (pre_q & pre_mask) == pre_mask;
    end
  end

  assign cnt_tick = tick & ~halt_q;

  // prescaler is cleared together with the counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 6'h00;
    end else if (clear_cnt) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= 6'(pre_q + 6'h01);
    end
  end

  // ---------------------------------------------------------------
  // modulo up-counter
  // ---------------------------------------------------------------
  assign wrap_evt = cnt_tick & (cnt_q == limit_q);
  assign cnt_nxt = wrap_evt ? '0 : CNT_W'(cnt_q + 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (clear_cnt) begin
      cnt_q <= '0; // restart from zero
    end else if (cnt_tick) begin
      cnt_q <= cnt_nxt;
    end
  end

  // timer control fields; halt starts set so only the prescaler counts until cleared
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_q <= TCCP_HALT_RST;
      wrap_ie_q <= 1'b0;
      ps_q <= TCCP_PS_RST;
      limit_q <= TCCP_LIMIT_RST;
    end else begin
      if (wr_tctrl) begin
        halt_q <= hwdata[TCCP_HALT_BIT];
        wrap_ie_q <= hwdata[TCCP_WRAP_IE_BIT];
        ps_q <= hwdata[TCCP_PS_LSB +: 3];
      end
      if (wr_limit) begin
        limit_q <= hwdata[CNT_W-1:0];
      end
    end
  end

  // wrap flag: read while set arms it, then writing zero clears; a new wrap wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wrap_flag_q <= 1'b0;
      wrap_arm_q <= 1'b0;
      wrap_req_q <= 1'b0;
    end else begin
      if (wrap_evt) begin
        wrap_flag_q <= 1'b1;
      end else if (wr_tctrl && wrap_arm_q && !hwdata[TCCP_WRAP_FLAG_BIT]) begin
        wrap_flag_q <= 1'b0;
      end
      if (rd_q && addr_q == TCCP_OFF_TIMER_CTRL && wrap_flag_q) begin
        wrap_arm_q <= 1'b1;
      end else if (wr_tctrl || wrap_evt) begin
        wrap_arm_q <= 1'b0; // a wrap during the sequence forces a re-read
      end
      wrap_req_q <= wrap_flag_q & wrap_ie_q;
    end
  end

  // ---------------------------------------------------------------
  // linked pair selection
  // ---------------------------------------------------------------
  assign link = ctrl_q[0].mode_select_high; // high bit outranks low bit

  always_comb begin
    last_d = last_q;
    if (wr_val[0]) begin
      last_d = 1'b0;
    end
    if (wr_val[1]) begin
      last_d = 1'b1;
    end
  end

  // pair 0 leads; the last written pair takes over only at a wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
      last_q <= 1'b0;
    end else if (!link) begin
      act_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      last_q <= last_d;
      if (wrap_evt) begin
        act_q <= last_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic [CNT_W-1:0] cmp_val;
    logic active;
    logic drive;
    logic pin_d;
    logic [1:0] els;

    // channel 1 does nothing of its own while linked
    assign active = (i == 0) || !link;
    // in the linked case pin 0 uses the live value of the active pair
    assign cmp_val = (i == 0 && link) ? val_q[act_q] : val_q[i];
    // equality on the next count only: a value already passed waits a period
    assign cmp_evt[i] = active && cnt_tick && (cnt_nxt == cmp_val);
    assign els = {ctrl_q[i].edge_level_sel_high, ctrl_q[i].edge_level_sel_low};
    assign drive = active && (ctrl_q[i].mode_select_high || ctrl_q[i].mode_select_low)
                   && (els != 2'b00);

    // wrap toggle starts the pulse, the compare action ends it
    always_comb begin
      pin_d = pin_q[i];
      if (wrap_evt && ctrl_q[i].toggle_on_wrap_bit) begin
        pin_d = ~pin_d;
      end
      if (cmp_evt[i]) begin
        unique case (els)
          2'b01: pin_d = ~pin_d;
          2'b10: pin_d = 1'b0;
          2'b11: pin_d = 1'b1;
          default: pin_d = pin_q[i];
        endcase
      end
    end

    // released pins hold their last level so a later enable starts clean
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_q[i] <= 1'b0;
        oe_n_q[i] <= 1'b1;
      end else begin
        oe_n_q[i] <= ~drive; // channel 1 pin freed when linked
        if (drive) begin
          pin_q[i] <= pin_d;
        end
      end
    end

    // control and value registers; writes replace the value at once
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl_q[i] <= TCCP_CHAN_CTRL_RST;
        val_q[i] <= TCCP_VAL_RST;
      end else begin
        if (wr_cctrl[i]) begin
          ctrl_q[i].irq_en <= hwdata[6];
          ctrl_q[i].mode_select_high <= hwdata[5];
          ctrl_q[i].mode_select_low <= hwdata[4];
          ctrl_q[i].edge_level_sel_high <= hwdata[3];
          ctrl_q[i].edge_level_sel_low <= hwdata[2];
          ctrl_q[i].toggle_on_wrap_bit <= hwdata[1];
        end
        if (wr_val[i]) begin
          val_q[i] <= hwdata[CNT_W-1:0]; // no shadow stage
        end
        if (cmp_evt[i]) begin
          ctrl_q[i].flag <= 1'b1; // set wins over a clearing write
        end else if (wr_cctrl[i] && arm_q[i] && !hwdata[7]) begin
          ctrl_q[i].flag <= 1'b0;
        end
      end
    end

    // clear sequence arming, same two steps as the wrap flag
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        arm_q[i] <= 1'b0;
        chan_req_q[i] <= 1'b0;
      end else begin
        if (rd_q && ctrl_q[i].flag &&
            addr_q == ((i == 0) ? TCCP_OFF_CH0_CTRL : TCCP_OFF_CH1_CTRL)) begin
          arm_q[i] <= 1'b1;
        end else if (wr_cctrl[i] || cmp_evt[i]) begin
          arm_q[i] <= 1'b0;
        end
        chan_req_q[i] <= ctrl_q[i].flag & ctrl_q[i].irq_en & active;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0; // always okay
  assign hrdata = hrdata_q;
  assign chan_pin_o = pin_q;
  assign chan_pin_oe_n = oe_n_q;
  assign wrap_req = wrap_req_q;
  assign chan_req = chan_req_q;

endmodule // tccp_timer

// File: verif/tb_timer_compare_pwm_channels.sv
`timescale 1ns/1ps
module tb_timer_compare_pwm_channels
  import tccp_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_clk_pin = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready;
  logic hreadyout, hresp, wrap_req;
  logic [31:0] hrdata, q;
  logic [1:0] chan_pin_o, chan_pin_oe_n, chan_req;
  int err_count = 0, checks_done = 0, cyc = 0, h, lo;

  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  tccp_timer tccp_timer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clk_pin(ext_clk_pin),
    .chan_pin_o(chan_pin_o), .chan_pin_oe_n(chan_pin_oe_n), .wrap_req(wrap_req),
    .chan_req(chan_req)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task finish_test();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one single transfer; ready is judged at the negedge before each edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge hclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // high and low lengths of the next whole period on pin 0
  task meas(output int hi, output int lw);
    hi = 0;
    lw = 0;
    while (chan_pin_o[0] !== 1'b0) @(negedge hclk);
    while (chan_pin_o[0] !== 1'b1) @(negedge hclk);
    while (chan_pin_o[0] === 1'b1) begin
      hi++;
      @(negedge hclk);
    end
    while (chan_pin_o[0] === 1'b0) begin
      lw++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset();
    rd(TCCP_OFF_TIMER_CTRL);
    chk(q, 32'h20);
    rd(TCCP_OFF_LIMIT);
    chk(q, {16'h0, TCCP_LIMIT_RST});
    repeat (20) @(posedge hclk);
    rd(TCCP_OFF_COUNT);
    chk(q, 32'h0);
    rd(8'h1C);
    chk(q, 32'h0);
    chk(32'(chan_pin_oe_n), 32'h3);
  endtask

  task t_pwm();
    wr(TCCP_OFF_TIMER_CTRL, 32'h30);
    wr(TCCP_OFF_LIMIT, 32'hFF);
    wr(TCCP_OFF_CH0_VAL, 32'h80);
    wr(TCCP_OFF_CH0_CTRL, 32'h5A);
    wr(TCCP_OFF_TIMER_CTRL, 32'h40);
    meas(h, lo);
    chk(32'(h), 32'h80);
    chk(32'(h + lo), 32'h100);
    chk(32'(wrap_req), 32'h1);
    chk(32'(chan_req), 32'h1);
    chk(32'(chan_pin_oe_n), 32'h2);
    rd(TCCP_OFF_TIMER_CTRL);
    chk(q & 32'hC0, 32'hC0);
  endtask

  task t_unbuf();
    // lower the width from the compare service, once the pulse has ended
    while (chan_pin_o[0] !== 1'b0) @(negedge hclk);
    @(posedge hclk);
    wr(TCCP_OFF_CH0_VAL, 32'h40);
    meas(h, lo);
    chk(32'(h), 32'h40);
    // raise it from the wrap service; the old value 40 passes with no compare
    wr(TCCP_OFF_CH0_VAL, 32'h60);
    repeat (80) @(negedge hclk);
    chk(32'(chan_pin_o[0]), 32'h1);
    meas(h, lo);
    chk(32'(h), 32'h60);
    // write a smaller value behind the count while the old one is ahead
    repeat (36) @(posedge hclk);
    wr(TCCP_OFF_CH0_VAL, 32'h20);
    repeat (100) @(negedge hclk);
    chk(32'(chan_pin_o[0]), 32'h1);
    @(posedge hclk);
  endtask

  task t_link();
    wr(TCCP_OFF_TIMER_CTRL, 32'h30);
    rd(TCCP_OFF_COUNT);
    chk(q, 32'h0);
    rd(TCCP_OFF_TIMER_CTRL);
    chk(q & 32'h7F, 32'h20);
    wr(TCCP_OFF_CH0_VAL, 32'h80);
    wr(TCCP_OFF_CH0_CTRL, 32'h2A);
    wr(TCCP_OFF_CH1_CTRL, 32'h1E);
    wr(TCCP_OFF_TIMER_CTRL, 32'h00);
    meas(h, lo);
    chk(32'(h), 32'h80);
    wr(TCCP_OFF_CH1_VAL, 32'h40);
    meas(h, lo);
    chk(32'(h), 32'h40);
    chk(32'(chan_pin_oe_n), 32'h2);
    rd(TCCP_OFF_CH0_CTRL);
    chk(q & 32'h7F, 32'h2A);
    wr(TCCP_OFF_CH0_VAL, 32'hC0);
    meas(h, lo);
    chk(32'(h), 32'hC0);
  endtask

  // set-on-compare gives a low pulse from the wrap up to the match
  task t_setlow();
    wr(TCCP_OFF_CH0_CTRL, 32'h1E);
    meas(h, lo);
    chk(32'(lo), 32'hC0);
    chk(32'(h + lo), 32'h100);
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  // a hang anywhere is cut off well past the longest expected run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_pwm();
    t_unbuf();
    t_link();
    t_setlow();
    finish_test();
  end
endmodule // tb_timer_compare_pwm_channels

// File: verif/tccp_timer_assertions.sv
`timescale 1ns/1ps
module tccp_timer_assertions
  import tccp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ext_clk_pin,
  input wire logic [1:0] chan_pin_o,
  input wire logic [1:0] chan_pin_oe_n,
  input wire logic wrap_req,
  input wire logic [1:0] chan_req
);
  logic wr_q, any_q, ie_q, halt_q;
  logic [5:0] off_q;
  logic [7:0] c0_q;
  wire tk = hsel & htrans[1] & hready;

  // ---------------------------------------------------------------
  // shadow of written control bits
  // ---------------------------------------------------------------
  // writes end with no wait state, so the shadow moves with the register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      off_q <= 6'h0;
      any_q <= 1'b0;
      ie_q <= 1'b0;
      halt_q <= TCCP_HALT_RST;
      c0_q <= 8'h00;
    end else if (hready) begin
      wr_q <= tk & hwrite;
      off_q <= haddr[7:2];
      if (wr_q) begin
        any_q <= 1'b1;
        if (off_q == TCCP_OFF_TIMER_CTRL[7:2]) begin
          ie_q <= hwdata[TCCP_WRAP_IE_BIT];
          halt_q <= hwdata[TCCP_HALT_BIT];
        end
        if (off_q == TCCP_OFF_CH0_CTRL[7:2]) begin
          c0_q <= hwdata[7:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  okay_resp_a:
    assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a:
    assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
  write_nowait_a:
    assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
  rdata_hold_a:
    assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
      else $error("read data moved outside a read");
  link_release_a:
    assert property (c0_q[5] && $past(c0_q[5]) |-> chan_pin_oe_n[1] && !chan_req[1])
      else $error("pin 1 not released while linked");
  pin0_drive_a:
    assert property ($stable(c0_q) |->
      chan_pin_oe_n[0] == !(c0_q[5:4] != 2'b00 && c0_q[3:2] != 2'b00))
      else $error("pin 0 enable disagrees with control");
  wrap_irq_a:
    assert property ($rose(wrap_req) |-> ie_q || $past(ie_q))
      else $error("wrap request without enable");
  chan_irq_a:
    assert property ($rose(chan_req[0]) |-> c0_q[6] || $past(c0_q[6]))
      else $error("channel request without enable");
  idle_reset_a:
    assert property (!any_q |-> chan_pin_oe_n == 2'b11 && chan_pin_o == 2'b00
      && wrap_req == 1'b0 && chan_req == 2'b00) else $error("activity before setup");
  halt_still_a:
    assert property (halt_q && $past(halt_q) && $past(halt_q, 2) |-> $stable(chan_pin_o))
      else $error("pin moved while halted");

  cover property (tk && !hwrite);
  cover property ($rose(wrap_req));
  cover property ($rose(chan_req[0]));
  cover property (c0_q[5] && !chan_pin_oe_n[0]);
endmodule // tccp_timer_assertions

bind tccp_timer tccp_timer_assertions #(.CNT_W(CNT_W)) tccp_timer_assertions_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clk_pin(ext_clk_pin),
  .chan_pin_o(chan_pin_o), .chan_pin_oe_n(chan_pin_oe_n), .wrap_req(wrap_req),
  .chan_req(chan_req)
);
